// File: dv/feinit_assertions.sv
`timescale 1ns/100ps
module feinit_assertions #(
    parameter int INIT_WAIT_CYCLES = 50
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // supplies and state
    input wire logic        vdd_ok,
    input wire logic        vddio_ok,
    input wire logic        feature_ready,
    input wire logic [1:0]  power_mode,
    input wire logic        accel_active
);
    logic        start_seen;
    logic        supply_ok;
    logic [23:0] since_reg;
    logic [23:0] since_next;

    // a start write being answered, and both supplies in range
    assign start_seen = pready && psel && penable && pwrite
        && paddr == feinit_pkg::OFS_INIT_CTRL && pwdata[7:0] == feinit_pkg::INIT_CTRL_START;
    assign supply_ok = vdd_ok && vddio_ok;

    // edges since the last start write; saturates so a stale start never wraps round
    always_comb begin
        since_next = since_reg;
        if (start_seen) begin
            since_next = 24'h0;
        end else if (since_reg != 24'hffffff) begin
            since_next = since_reg + 24'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_reg <= 24'hffffff;
        end else begin
            since_reg <= since_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_state :
        assert property ($rose(presetn) |-> !feature_ready && power_mode == 2'h0 && !pready)
        else $error("outputs not at rest after reset release");
    a_answer_next :
        assert property (psel && penable && !pready && supply_ok && $past(supply_ok) |=> pready)
        else $error("access phase not answered on the next edge");
    a_answer_single :
        assert property (pready |=> !pready)
        else $error("answer held longer than one cycle");
    a_answer_asked :
        assert property (pready |-> $past(psel) && $past(penable))
        else $error("answer without an access phase");
    a_err_with_ready :
        assert property (pslverr |-> pready && $past(penable))
        else $error("error flag outside an answer");
    a_start_delay :
        assert property ($rose(feature_ready) |-> since_reg == INIT_WAIT_CYCLES)
        else $error("engine ready at the wrong distance from the start write");
    a_ready_holds :
        assert property (feature_ready && supply_ok && $past(supply_ok) |=> feature_ready)
        else $error("engine ready dropped while supplies were in range");
    a_supply_clear :
        assert property (!supply_ok [*2] |=> !feature_ready && !accel_active && !pready)
        else $error("state survived a supply loss");
    a_fast_mode_cause :
        assert property (power_mode[1] |-> accel_active)
        else $error("active power mode without accel enabled");

    c_engine_ready : cover property ($rose(feature_ready));
    c_bus_error    : cover property (pslverr);
    c_supply_loss  : cover property (!supply_ok ##1 supply_ok);
endmodule

// File: dv/feinit_host.sv
`timescale 1ns/100ps
module feinit_host (
    // clock
    input wire logic        pclk,
    // apb master
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    // bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer; released data is inverted so a stale value never looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/100ps
module tb;
    localparam int INIT_WAIT = 50;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        vdd_ok, vddio_ok, feature_ready, accel_active;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  power_mode;
    int          bad_count, samples_checked;

    feinit_top #(.INIT_WAIT_CYCLES(INIT_WAIT)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .vdd_ok(vdd_ok),
        .vddio_ok(vddio_ok), .feature_ready(feature_ready), .power_mode(power_mode),
        .accel_active(accel_active));
    feinit_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        u_host.xfer(1'b0, a, 32'h0, d, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        u_host.xfer(1'b1, a, d, r, e);
    endtask

    task automatic t_boot;
        logic [31:0] d;
        chk({29'h0, feature_ready, power_mode}, 32'h0, "boot state");
        rd(feinit_pkg::OFS_CHIP_ID, d);
        chk(d & 32'hff, {24'h0, feinit_pkg::CHIP_ID_VALUE}, "chip id");
        rd(feinit_pkg::OFS_POWER_CONFIG, d);
        chk(d & 32'h3, 32'h1, "power config at boot");
        $display("test boot done");
    endtask

    // same bus phase for both reads, so exactly two ticks must separate them
    task automatic t_time;
        logic [31:0] a, b;
        rd(feinit_pkg::OFS_TIME_LOW, a);
        repeat (2 * feinit_pkg::STIME_TICK_CYCLES - 4) @(posedge pclk);
        rd(feinit_pkg::OFS_TIME_LOW, b);
        chk((b - a) & 32'hff, 32'h2, "time ticks");
        $display("test time done");
    endtask

    task automatic t_load;
        logic [31:0] d;
        logic [7:0]  img [8];
        wr(feinit_pkg::OFS_POWER_CONFIG, 32'h0);
        repeat (45000) @(posedge pclk);
        wr(feinit_pkg::OFS_INIT_CTRL, {24'h0, feinit_pkg::INIT_CTRL_LOAD});
        for (int i = 0; i < 8; i++) begin
            img[i] = 8'h3c + 8'(i * 37);
            wr(feinit_pkg::OFS_FEATURE_PORT, {24'h0, img[i]});
            if (i == 3) begin
                rd(feinit_pkg::OFS_LOAD_POS, d);
                chk(d & 32'h7f, 32'h4, "first burst count");
            end
        end
        rd(feinit_pkg::OFS_LOAD_POS, d);
        chk(d & 32'h7f, 32'h8, "fill count");
        wr(feinit_pkg::OFS_LOAD_POS, 32'h0);
        for (int i = 0; i < 9; i++) begin
            rd(feinit_pkg::OFS_FEATURE_PORT, d);
            chk(d & 32'hff, (i < 8) ? {24'h0, img[i]} : 32'h0, "image read back");
        end
        $display("test load done");
    endtask

    task automatic t_start;
        logic [31:0] d;
        int          n;
        wr(feinit_pkg::OFS_INIT_CTRL, {24'h0, feinit_pkg::INIT_CTRL_START});
        rd(feinit_pkg::OFS_INTERNAL_STATUS, d);
        chk(d & 32'hf, 32'h0, "no early ready");
        n = 0;
        while (d[3:0] !== feinit_pkg::MSG_INIT_OK && n < 40) begin
            rd(feinit_pkg::OFS_INTERNAL_STATUS, d);
            n++;
        end
        chk(d & 32'hf, {28'h0, feinit_pkg::MSG_INIT_OK}, "status message");
        chk({31'h0, feature_ready}, 32'h1, "engine ready");
        chk({30'h0, power_mode}, {30'h0, feinit_pkg::PM_CONFIG}, "config mode");
        $display("test start done");
    endtask

    task automatic t_modes;
        logic [31:0] d;
        logic        e;
        wr(feinit_pkg::OFS_POWER_CTRL, 32'h1);
        wr(feinit_pkg::OFS_POWER_CONFIG, 32'h2);
        repeat (2) @(posedge pclk); // mode output lags the register by one edge
        chk({30'h0, power_mode}, {30'h0, feinit_pkg::PM_PERF}, "perf mode");
        u_host.xfer(1'b0, 8'h3c, 32'h0, d, e);
        chk({31'h0, e}, 32'h1, "unmapped read");
        wr(feinit_pkg::OFS_POWER_CONFIG, 32'h1);
        repeat (2) @(posedge pclk);
        chk({30'h0, power_mode}, {30'h0, feinit_pkg::PM_LOWPOWER}, "low power mode");
        $display("test modes done");
    endtask

    // each supply in turn drops while accel is on
    task automatic t_supply;
        logic [31:0] d;
        for (int i = 0; i < 2; i++) begin
            // first pass is already in low power with accel on: no write so soon
            if (i == 1) wr(feinit_pkg::OFS_POWER_CTRL, 32'h1);
            repeat (2) @(posedge pclk);
            chk({31'h0, accel_active}, 32'h1, "accel on");
            if (i == 0) vdd_ok <= 1'b0;
            else vddio_ok <= 1'b0;
            repeat (3) @(posedge pclk);
            vdd_ok <= 1'b1;
            vddio_ok <= 1'b1;
            repeat (3) @(posedge pclk);
            chk({30'h0, feature_ready, accel_active}, 32'h0, "cleared by supply");
            chk({30'h0, power_mode}, 32'h0, "suspend after supply");
            rd(feinit_pkg::OFS_POWER_CONFIG, d);
            chk(d & 32'h3, 32'h1, "power config after supply");
        end
        $display("test supply done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        vdd_ok = 1'b1;
        vddio_ok = 1'b1;
        bad_count = 0;
        samples_checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_boot;
        t_time;
        t_load;
        t_start;
        t_modes;
        t_supply;
        // supply loss was a device reset, so the whole start-up runs again
        t_load;
        t_start;
        summarize;
    end

    // watchdog just beyond the ~98k cycles the tests need
    initial begin
        #1000000;
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        summarize;
    end
endmodule

bind feinit_top feinit_assertions #(.INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .vdd_ok(vdd_ok), .vddio_ok(vddio_ok), .feature_ready(feature_ready),
    .power_mode(power_mode), .accel_active(accel_active));

// File: hw/feinit_stime.sv
`timescale 1ns/100ps
module feinit_stime (
    // clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // supply-loss restart
    input  wire logic                              clear,
    // free-running time
    output logic      [feinit_pkg::STIME_W-1:0]    time_count
);

    localparam logic [feinit_pkg::STIME_DIV_W-1:0] DIV_LAST =
        feinit_pkg::STIME_DIV_W'(feinit_pkg::STIME_TICK_CYCLES - 1);

    logic [feinit_pkg::STIME_DIV_W-1:0] div_reg;
    logic [feinit_pkg::STIME_DIV_W-1:0] div_next;
    logic [feinit_pkg::STIME_W-1:0]     time_reg;
    logic [feinit_pkg::STIME_W-1:0]     time_next;
    logic                               tick;

    // divider makes one enable pulse per time step
    always_comb begin
        tick      = (div_reg == DIV_LAST);
        div_next  = tick ? '0 : div_reg + 1'b1;
        time_next = tick ? time_reg + 1'b1 : time_reg;
        if (clear) begin
            div_next  = '0;
            time_next = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= '0;
            time_reg <= '0;
        end else begin
            div_reg  <= div_next;
            time_reg <= time_next;
        end
    end

    assign time_count = time_reg;

endmodule

// File: hw/feinit_top.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module feinit_top #(
    parameter int INIT_WAIT_CYCLES = feinit_pkg::INIT_DONE_CYCLES
) (
    // clock and reset
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    // apb slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [feinit_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [feinit_pkg::DATA_W-1:0]      pwdata,
    output logic                                    pready,
    output logic      [feinit_pkg::DATA_W-1:0]      prdata,
    output logic                                    pslverr,
    // supply monitors, high while in range
    input  wire logic                               vdd_ok,
    input  wire logic                               vddio_ok,
    // engine and power state
    output logic                                    feature_ready,
    output logic      [1:0]                         power_mode,
    output logic                                    accel_active
);

    localparam logic [feinit_pkg::INIT_CNT_W-1:0] INIT_LAST =
        feinit_pkg::INIT_CNT_W'(INIT_WAIT_CYCLES - 1);
    localparam logic [feinit_pkg::PTR_W-1:0] PTR_FULL =
        feinit_pkg::PTR_W'(feinit_pkg::IMAGE_DEPTH);

    // zero-extend one byte onto the bus word
    function automatic logic [feinit_pkg::DATA_W-1:0] byte_word(input logic [7:0] b);
        byte_word = {24'h000000, b};
    endfunction

    // image index from a pointer that is known to be in range
    function automatic logic [5:0] img_idx(input logic [feinit_pkg::PTR_W-1:0] p);
        img_idx = p[5:0];
    endfunction

    logic                                   supply_lost;
    logic                                   access;
    logic                                   wr_done;
    logic                                   rd_done;
    logic [feinit_pkg::STIME_W-1:0]         time_count;

    // bus answer registers
    logic                                   pready_reg;
    logic                                   pready_next;
    logic [feinit_pkg::DATA_W-1:0]          prdata_reg;
    logic [feinit_pkg::DATA_W-1:0]          prdata_next;
    logic                                   pslverr_reg;
    logic                                   pslverr_next;

    // control registers
    logic [1:0]                             power_config_reg;
    logic [1:0]                             power_config_next;
    logic                                   power_ctrl_reg;
    logic                                   power_ctrl_next;
    logic [7:0]                             init_ctrl_reg;
    logic [7:0]                             init_ctrl_next;

    // image store and pointers
    logic [7:0]                             image_reg [feinit_pkg::IMAGE_DEPTH];
    logic [7:0]                             image_next [feinit_pkg::IMAGE_DEPTH];
    logic [feinit_pkg::PTR_W-1:0]           wr_ptr_reg;
    logic [feinit_pkg::PTR_W-1:0]           wr_ptr_next;
    logic [feinit_pkg::PTR_W-1:0]           rd_ptr_reg;
    logic [feinit_pkg::PTR_W-1:0]           rd_ptr_next;
    logic                                   overflow_reg;
    logic                                   overflow_next;

    // engine sequencer
    feinit_pkg::feinit_fe_state_e           fe_state_reg;
    feinit_pkg::feinit_fe_state_e           fe_state_next;
    logic [feinit_pkg::INIT_CNT_W-1:0]      wait_cnt_reg;
    logic [feinit_pkg::INIT_CNT_W-1:0]      wait_cnt_next;
    logic [feinit_pkg::MSG_W-1:0]           message_reg;
    logic [feinit_pkg::MSG_W-1:0]           message_next;

    // output state
    logic                                   feature_ready_reg;
    logic [1:0]                             power_mode_reg;
    logic                                   accel_active_reg;
    feinit_pkg::feinit_power_mode_e         mode_now;

    // losing either supply restarts everything, like power-on
    assign supply_lost = !(vdd_ok && vddio_ok);
    assign access      = psel && penable;
    assign wr_done     = access && pready_reg && pwrite;
    assign rd_done     = access && pready_reg && !pwrite;

    feinit_stime u_stime (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (supply_lost),
        .time_count (time_count)
    );

    // one wait state: read data is sampled on the first access cycle
    always_comb begin
        pready_next  = access && !pready_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (access && !pready_reg) begin
            prdata_next = '0;
            unique case (paddr)
                feinit_pkg::OFS_CHIP_ID:      prdata_next = byte_word(feinit_pkg::CHIP_ID_VALUE);
                feinit_pkg::OFS_POWER_CONFIG: prdata_next = {30'h00000000, power_config_reg};
                feinit_pkg::OFS_POWER_CTRL:   prdata_next = {31'h00000000, power_ctrl_reg};
                feinit_pkg::OFS_TIME_LOW:     prdata_next = byte_word(time_count[7:0]);
                feinit_pkg::OFS_TIME_MID:     prdata_next = byte_word(time_count[15:8]);
                feinit_pkg::OFS_TIME_HIGH:    prdata_next = byte_word(time_count[23:16]);
                feinit_pkg::OFS_INIT_CTRL:    prdata_next = byte_word(init_ctrl_reg);
                feinit_pkg::OFS_FEATURE_PORT: begin
                    // bytes past the fill level read as zero
                    if (rd_ptr_reg < wr_ptr_reg) begin
                        prdata_next = byte_word(image_reg[img_idx(rd_ptr_reg)]);
                    end
                end
                feinit_pkg::OFS_LOAD_POS:     prdata_next = {25'h0000000, wr_ptr_reg};
                feinit_pkg::OFS_INTERNAL_STATUS: begin
                    prdata_next[feinit_pkg::MSG_W-1:0] = message_reg;
                    prdata_next[feinit_pkg::OVF_BIT]   = overflow_reg;
                end
                feinit_pkg::OFS_POWER_STATE:  prdata_next = {30'h00000000, power_mode_reg};
                default:                      pslverr_next = 1'b1;
            endcase
        end
        if (supply_lost) begin
            pready_next  = 1'b0;
            prdata_next  = '0;
            pslverr_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // control registers, image loading and engine sequencing
    always_comb begin
        power_config_next = power_config_reg;
        power_ctrl_next   = power_ctrl_reg;
        init_ctrl_next    = init_ctrl_reg;
        image_next        = image_reg;
        wr_ptr_next       = wr_ptr_reg;
        rd_ptr_next       = rd_ptr_reg;
        overflow_next     = overflow_reg;
        fe_state_next     = fe_state_reg;
        wait_cnt_next     = wait_cnt_reg;
        message_next      = message_reg;

        if (wr_done) begin
            unique case (paddr)
                feinit_pkg::OFS_POWER_CONFIG: power_config_next = pwdata[1:0];
                feinit_pkg::OFS_POWER_CTRL:   power_ctrl_next   = pwdata[feinit_pkg::ACC_EN_BIT];
                feinit_pkg::OFS_INIT_CTRL: begin
                    init_ctrl_next = pwdata[7:0];
                    // 0x00 opens (or reopens) the load window and rewinds the image
                    if (pwdata[7:0] == feinit_pkg::INIT_CTRL_LOAD &&
                        (fe_state_reg == feinit_pkg::FE_UNINIT ||
                         fe_state_reg == feinit_pkg::FE_LOADING)) begin
                        fe_state_next = feinit_pkg::FE_LOADING;
                        wr_ptr_next   = '0;
                        rd_ptr_next   = '0;
                        overflow_next = 1'b0;
                    end
                    // start is honoured only from the load window, so a repeat is inert
                    if (pwdata[7:0] == feinit_pkg::INIT_CTRL_START &&
                        fe_state_reg == feinit_pkg::FE_LOADING) begin
                        fe_state_next = feinit_pkg::FE_STARTING;
                        wait_cnt_next = '0;
                    end
                end
                feinit_pkg::OFS_FEATURE_PORT: begin
                    // filling resumes at the pointer, whatever burst the byte belongs to
                    if (fe_state_reg == feinit_pkg::FE_LOADING) begin
                        if (wr_ptr_reg < PTR_FULL) begin
                            image_next[img_idx(wr_ptr_reg)] = pwdata[7:0];
                            wr_ptr_next = wr_ptr_reg + 1'b1;
                        end else begin
                            overflow_next = 1'b1; // excess bytes dropped, not wrapped
                        end
                    end
                end
                feinit_pkg::OFS_LOAD_POS: rd_ptr_next = pwdata[feinit_pkg::PTR_W-1:0];
                default: ;
            endcase
        end

        // read-back walks its own pointer so verification never disturbs filling
        if (rd_done && paddr == feinit_pkg::OFS_FEATURE_PORT && rd_ptr_reg < wr_ptr_reg) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
        end

        // engine boot time; message flips exactly at the end of it
        if (fe_state_reg == feinit_pkg::FE_STARTING) begin
            if (wait_cnt_reg == INIT_LAST) begin
                fe_state_next = feinit_pkg::FE_READY;
                message_next  = feinit_pkg::MSG_INIT_OK;
            end else begin
                wait_cnt_next = wait_cnt_reg + 1'b1;
            end
        end

        if (supply_lost) begin
            power_config_next = feinit_pkg::POWER_CONFIG_RST;
            power_ctrl_next   = 1'b0;
            init_ctrl_next    = feinit_pkg::INIT_CTRL_RST;
            wr_ptr_next       = '0;
            rd_ptr_next       = '0;
            overflow_next     = 1'b0;
            fe_state_next     = feinit_pkg::FE_UNINIT;
            wait_cnt_next     = '0;
            message_next      = feinit_pkg::MSG_NOT_INIT;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_config_reg <= feinit_pkg::POWER_CONFIG_RST;
            power_ctrl_reg   <= 1'b0;
            init_ctrl_reg    <= feinit_pkg::INIT_CTRL_RST;
            wr_ptr_reg       <= '0;
            rd_ptr_reg       <= '0;
            overflow_reg     <= 1'b0;
            fe_state_reg     <= feinit_pkg::FE_UNINIT;
            wait_cnt_reg     <= '0;
            message_reg      <= feinit_pkg::MSG_NOT_INIT;
        end else begin
            power_config_reg <= power_config_next;
            power_ctrl_reg   <= power_ctrl_next;
            init_ctrl_reg    <= init_ctrl_next;
            wr_ptr_reg       <= wr_ptr_next;
            rd_ptr_reg       <= rd_ptr_next;
            overflow_reg     <= overflow_next;
            fe_state_reg     <= fe_state_next;
            wait_cnt_reg     <= wait_cnt_next;
            message_reg      <= message_next;
        end
    end

    // image bytes need no reset; only bytes below the fill level are ever shown
    always_ff @(posedge pclk) begin
        image_reg <= image_next;
    end

    // power mode from save bit, perf bit and accel enable
    always_comb begin
        if (!power_config_reg[feinit_pkg::ADV_SAVE_BIT] && !power_ctrl_reg) begin
            mode_now = feinit_pkg::PM_CONFIG;
        end else if (!power_ctrl_reg) begin
            mode_now = feinit_pkg::PM_SUSPEND;
        end else if (power_config_reg[feinit_pkg::PERF_BIT]) begin
            mode_now = feinit_pkg::PM_PERF;
        end else begin
            mode_now = feinit_pkg::PM_LOWPOWER;
        end
    end

    // registered status outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feature_ready_reg <= 1'b0;
            power_mode_reg    <= 2'(feinit_pkg::PM_SUSPEND);
            accel_active_reg  <= 1'b0;
        end else begin
            feature_ready_reg <= (fe_state_next == feinit_pkg::FE_READY);
            power_mode_reg    <= supply_lost ? 2'(feinit_pkg::PM_SUSPEND) : 2'(mode_now);
            accel_active_reg  <= !supply_lost && power_ctrl_reg;
        end
    end

    assign pready        = pready_reg;
    assign prdata        = prdata_reg;
    assign pslverr       = pslverr_reg;
    assign feature_ready = feature_ready_reg;
    assign power_mode    = power_mode_reg;
    assign accel_active  = accel_active_reg;

endmodule

// File: shared/feinit_pkg.sv
package feinit_pkg;

    // bus geometry
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // register byte offsets
    localparam logic [7:0]  OFS_CHIP_ID         = 8'h00;
    localparam logic [7:0]  OFS_POWER_CONFIG    = 8'h04;
    localparam logic [7:0]  OFS_POWER_CTRL      = 8'h08;
    localparam logic [7:0]  OFS_TIME_LOW        = 8'h0c;
    localparam logic [7:0]  OFS_TIME_MID        = 8'h10;
    localparam logic [7:0]  OFS_TIME_HIGH       = 8'h14;
    localparam logic [7:0]  OFS_INIT_CTRL       = 8'h18;
    localparam logic [7:0]  OFS_FEATURE_PORT    = 8'h1c;
    localparam logic [7:0]  OFS_LOAD_POS        = 8'h20;
    localparam logic [7:0]  OFS_INTERNAL_STATUS = 8'h24;
    localparam logic [7:0]  OFS_POWER_STATE     = 8'h28;

    // identity value, arbitrary
    localparam logic [7:0]  CHIP_ID_VALUE = 8'h5a;

    // field layout and reset values
    localparam int          ADV_SAVE_BIT     = 0;
    localparam int          PERF_BIT         = 1;
    localparam int          ACC_EN_BIT       = 0;
    localparam int          OVF_BIT          = 4;
    localparam int          MSG_W            = 4;
    localparam logic [1:0]  POWER_CONFIG_RST = 2'h1;
    localparam logic [7:0]  INIT_CTRL_RST    = 8'h00;
    localparam logic [7:0]  INIT_CTRL_LOAD   = 8'h00;
    localparam logic [7:0]  INIT_CTRL_START  = 8'h01;
    localparam logic [3:0]  MSG_NOT_INIT     = 4'h0;
    localparam logic [3:0]  MSG_INIT_OK      = 4'h1;

    // configuration image storage
    localparam int          IMAGE_DEPTH = 64;
    localparam int          PTR_W       = 7;

    // timing
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          STIME_TICK_NS     = 39250;
    localparam int          STIME_TICK_CYCLES = STIME_TICK_NS / CLK_PERIOD_NS;
    localparam int          STIME_DIV_W       = 12;
    localparam int          STIME_W           = 24;
    localparam int          INIT_DONE_MS      = 140;
    localparam int          INIT_DONE_CYCLES  = INIT_DONE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          INIT_CNT_W        = 24;

    // feature engine life cycle
    typedef enum logic [1:0] {
        FE_UNINIT,
        FE_LOADING,
        FE_STARTING,
        FE_READY
    } feinit_fe_state_e;

    // reported power mode
    typedef enum logic [1:0] {
        PM_SUSPEND,
        PM_CONFIG,
        PM_PERF,
        PM_LOWPOWER
    } feinit_power_mode_e;

endpackage
